// >>> logic/icr_consts.svh
// Function
// - Interrupt saves PC, accumulator, status, pointer
// - After save, PC jumps to 000h
// - Plain return opcode restores all context
// - Returns overwrite every status bit
// - Resume at interrupted instruction address
// - Adjusting return adds accumulator to counter first
// - Adjusting return then restores full context
// - Return takes 2 compatible, 3 fast cycles
`ifndef ICR_CONSTS_SVH
`define ICR_CONSTS_SVH
`define ICR_PC_W        12
`define ICR_DATA_W      8
`define ICR_VECTOR      12'h000
`define ICR_OP_RETI     12'h00e
`define ICR_OP_RETIW    12'h00f
`define ICR_CYC_COMPAT  2'h2
`define ICR_CYC_FAST    2'h3
`endif

// >>> logic/icr_context_return.sv
`timescale 1ns/1ps
`include "icr_consts.svh"
module icr_context_return
    import icr_pkg::*;
(
    input  wire logic        clock,       // Core clock, 10 MHz
    input  wire logic        rst,         // Async reset, active high
    input  wire logic        fastMode,    // High selects fast execution mode
    input  wire logic        irqReq,      // Interrupt request from core
    input  wire logic        opValid,     // Decoder presents an opcode
    input  wire logic [11:0] opcode,      // Decoded instruction word
    input  wire icr_ctx_s    liveCtx,     // Current PC, acc, status, pointer
    input  wire icr_byte_t   counterIn,   // Current realtime_counter value
    output icr_ctx_s         ctxOut,      // Context to load into core
    output logic             ctxLoad,     // Pulse: core loads ctxOut
    output icr_byte_t        counterOut,  // New realtime_counter value
    output logic             counterLoad, // Pulse: core loads counterOut
    output logic             irqAck,      // Pulse: interrupt accepted
    output logic             inService,   // Shadow set holds live context
    output logic             retBusy      // Return instruction in progress
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        icr_state_e st;
        logic [1:0] cyc;
        logic       adjust;
        icr_ctx_s   ctxOut;
        logic       ctxLoad;
        icr_byte_t  counterOut;
        logic       counterLoad;
        logic       irqAck;
        logic       inService;
        logic       busy;
    } icr_reg_s;

    // Registered state and its next value
    icr_reg_s s_r;
    icr_reg_s s_nxt;
    // Shadow read port and its write strobe
    icr_ctx_s shadowData;
    logic     saveEn;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Either return form starts the same restore sequence
    function automatic logic isReturn(input logic [11:0] op);
        return (op == `ICR_OP_RETI) || (op == `ICR_OP_RETIW);
    endfunction

    // Only the adjusting form touches the realtime_counter
    function automatic logic isAdjust(input logic [11:0] op);
        return op == `ICR_OP_RETIW;
    endfunction

    // Return length in cycles for the current execution mode
    function automatic logic [1:0] lastCycle(input logic fast);
        return fast ? `ICR_CYC_FAST : `ICR_CYC_COMPAT;
    endfunction

    wire logic retStart = opValid && isReturn(opcode) && (s_r.st == ICR_IDLE);
    // Accepting only while idle and out of service keeps one shadow set safe
    assign saveEn = irqReq && !s_r.inService && (s_r.st == ICR_IDLE) && !retStart;

    // ----------------------------------------------------------------
    // Shadow set
    // ----------------------------------------------------------------
    // A second set would allow nesting; one set is the cheaper choice
    icr_shadow i_icr_shadow (
        .clock  (clock),
        .rst    (rst),
        .wrEn   (saveEn),
        .wrData (liveCtx),
        .rdData (shadowData)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // A return's decode edge moves to BUSY and, for the adjusting form,
    // loads the counter sum; the restore waits at least two more cycles.
    // BUSY counts up to the mode's length, then LAST hands the shadow
    // copy back and clears the service flag in the same edge.
    always_comb begin
        s_nxt = s_r;
        s_nxt.ctxLoad = 1'b0;
        s_nxt.counterLoad = 1'b0;
        s_nxt.irqAck = 1'b0;
        unique case (s_r.st)
            ICR_IDLE: begin
                // A return outranks a request decoded in the same cycle
                if (retStart) begin
                    s_nxt.adjust = isAdjust(opcode);
                    s_nxt.cyc = 2'h1;
                    s_nxt.st = ICR_BUSY;
                    if (isAdjust(opcode)) begin
                        // Add happens first, in the decode cycle
                        s_nxt.counterOut = counterIn + liveCtx.acc;
                        s_nxt.counterLoad = 1'b1;
                    end
                end else if (saveEn) begin
                    s_nxt.irqAck = 1'b1;
                    s_nxt.inService = 1'b1;
                    s_nxt.ctxOut = liveCtx;
                    s_nxt.ctxOut.pc = `ICR_VECTOR;
                    s_nxt.ctxLoad = 1'b1;
                end
            end
            ICR_BUSY: begin
                s_nxt.cyc = s_r.cyc + 2'h1;
                // Last cycle count depends on execution mode
                if (s_nxt.cyc == lastCycle(fastMode)) begin
                    s_nxt.st = ICR_LAST;
                end
            end
            ICR_LAST: begin
                // Whole shadow copy, status included, back to the core
                s_nxt.ctxOut = shadowData;
                s_nxt.ctxLoad = 1'b1;
                s_nxt.inService = 1'b0;
                s_nxt.st = ICR_IDLE;
                s_nxt.cyc = 2'h0;
            end
            default: s_nxt.st = ICR_IDLE;
        endcase
        // Busy flag registered with the state so retBusy leaves a flip-flop
        s_nxt.busy = (s_nxt.st != ICR_IDLE);
    end

    // Registered state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Each output is a register bit, so the core never sees decode hazards
    assign ctxOut = s_r.ctxOut;
    assign ctxLoad = s_r.ctxLoad;
    assign counterOut = s_r.counterOut;
    assign counterLoad = s_r.counterLoad;
    assign irqAck = s_r.irqAck;
    assign inService = s_r.inService;
    assign retBusy = s_r.busy;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Entry must always land on the service vector
    a_ack_vector: assert property (@(posedge clock) disable iff (rst)
        irqAck |-> (ctxLoad && ctxOut.pc == 12'h000))
        else $error("Interrupt entry did not vector to zero");

    // The shadow copy is the context seen at the accepting edge
    a_ack_saves: assert property (@(posedge clock) disable iff (rst)
        irqAck |-> (shadowData == $past(liveCtx)))
        else $error("Context not captured on entry");

    // No second entry until the restore pulse has gone out
    a_no_nest: assert property (@(posedge clock) disable iff (rst)
        (inService && !ctxLoad) |-> !irqAck)
        else $error("Nested interrupt accepted");

    // Shadow must not move while a routine runs, or the return resumes wrongly
    a_shadow_hold: assert property (@(posedge clock) disable iff (rst)
        (inService && !irqAck) |-> $stable(shadowData))
        else $error("Shadow set changed while in service");

    // A return decoded beside a pending request wins the cycle
    a_ret_priority: assert property (@(posedge clock) disable iff (rst)
        (retStart && irqReq) |=> !irqAck)
        else $error("Interrupt accepted beside a return");

    // No entry may start while a return is still running
    a_busy_no_ack: assert property (@(posedge clock) disable iff (rst)
        retBusy |=> !irqAck)
        else $error("Interrupt accepted during a return");

    // Fast mode is read on the first two busy cycles, compatible on the first
    a_ret_fast: assert property (@(posedge clock) disable iff (rst)
        ($rose(retBusy) && fastMode) ##1 fastMode |-> retBusy[*2] ##1 !retBusy)
        else $error("Fast return length wrong");
    a_ret_compat: assert property (@(posedge clock) disable iff (rst)
        ($rose(retBusy) && !fastMode) |-> retBusy[*2] ##1 !retBusy)
        else $error("Compatible return length wrong");

    // Restore hands back the whole shadow copy, status bits included
    a_restore_all: assert property (@(posedge clock) disable iff (rst)
        $fell(retBusy) |-> (ctxLoad && ctxOut == shadowData))
        else $error("Return did not restore shadow context");

    // Resume address is the saved one and the service flag drops with it
    a_restore_pc: assert property (@(posedge clock) disable iff (rst)
        $fell(retBusy) |-> (ctxOut.pc == shadowData.pc && !inService))
        else $error("Return did not resume at saved address");

    // Plain return leaves the realtime_counter alone
    a_plain_nocount: assert property (@(posedge clock) disable iff (rst)
        (retStart && opcode == `ICR_OP_RETI) |=> !counterLoad)
        else $error("Plain return touched the counter");

    // Sum wraps at eight bits like the counter itself
    a_adjust_add: assert property (@(posedge clock) disable iff (rst)
        (retStart && opcode == 12'h00f) |=> (counterLoad
            && counterOut == $past(counterIn) + $past(liveCtx.acc)))
        else $error("Counter adjust wrong");

    // Counter load and context load never share a cycle
    a_add_then_load: assert property (@(posedge clock) disable iff (rst)
        counterLoad |-> !ctxLoad)
        else $error("Counter adjust overlapped the restore");

    // Restore follows the counter add within the return's length
    a_adjust_first: assert property (@(posedge clock) disable iff (rst)
        counterLoad |-> ##[1:3] (ctxLoad && !irqAck))
        else $error("Adjusting return did not restore");

    // ----------------------------------------------------------------
    // Coverage of the main scenarios
    // ----------------------------------------------------------------
    c_irq: cover property (@(posedge clock) irqAck);
    c_reti: cover property (@(posedge clock) $fell(retBusy) && !s_r.adjust);
    c_retiw: cover property (@(posedge clock) $fell(retBusy) && s_r.adjust);
    c_fast: cover property (@(posedge clock) retBusy && fastMode);
    c_priority: cover property (@(posedge clock) retStart && irqReq);
endmodule

// >>> logic/icr_pkg.sv
`include "icr_consts.svh"
package icr_pkg;
    typedef logic [`ICR_PC_W-1:0]   icr_pc_t;
    typedef logic [`ICR_DATA_W-1:0] icr_byte_t;

    // Context saved on interrupt entry
    typedef struct packed {
        icr_pc_t   pc;
        icr_byte_t acc;
        icr_byte_t status;
        icr_byte_t fsp;
    } icr_ctx_s;

    // Gray codes along idle -> busy -> done
    typedef enum logic [1:0] {
        ICR_IDLE = 2'b00,
        ICR_BUSY = 2'b01,
        ICR_LAST = 2'b11
    } icr_state_e;
endpackage

// >>> logic/icr_shadow.sv
`timescale 1ns/1ps
// Single shadow set; read data come out of a register.
module icr_shadow
    import icr_pkg::*;
(
    input  wire logic     clock,   // Core clock
    input  wire logic     rst,     // Async reset
    input  wire logic     wrEn,    // Capture context
    input  wire icr_ctx_s wrData,  // Context to save
    output icr_ctx_s      rdData   // Saved context
);
    // Shadow storage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else if (wrEn) begin
            rdData <= wrData;
        end
    end
endmodule

// >>> tb/icr_context_return_tb.sv
`timescale 1ns/1ps
`include "icr_consts.svh"
module icr_context_return_tb import icr_pkg::*; ();
    logic        clock, rst, fastMode, irqReq, opValid;
    logic [11:0] opcode;
    icr_ctx_s    liveCtx, ctxOut, expCtx;
    icr_byte_t   counterIn, counterOut;
    logic        ctxLoad, counterLoad, irqAck, inService, retBusy;
    int          err_count = 0, check_count = 0, cycles = 0, busyCnt, expCnt;
    logic [15:0] seed = 16'h0003;
    icr_ctx_s    savedQ[$];   // Reference copy of the shadow set

    icr_context_return i_icr_context_return (.clock(clock), .rst(rst), .fastMode(fastMode),
        .irqReq(irqReq), .opValid(opValid), .opcode(opcode), .liveCtx(liveCtx),
        .counterIn(counterIn), .ctxOut(ctxOut), .ctxLoad(ctxLoad), .counterOut(counterOut),
        .counterLoad(counterLoad), .irqAck(irqAck), .inService(inService), .retBusy(retBusy));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [39:0] got, input logic [39:0] want);
        check_count++;
        if (got !== want) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask

    // Fresh random core context and counter value
    task automatic newLive();
        logic [15:0] a, b;
        seed = lfsr(seed);
        a = seed;
        seed = lfsr(seed);
        b = seed;
        seed = lfsr(seed);
        liveCtx = {a[11:0], b[7:0], b[15:8], seed[7:0]};
        counterIn = seed[15:8];
    endtask

    task automatic results();
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // A full run needs well under 200 cycles; the margin covers slow returns
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            results();
        end
    end

    // ----------------------------------------
    // Stimulus: both modes times both return kinds
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {fastMode, irqReq, opValid, opcode, liveCtx, counterIn} = '0;
        repeat (10) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (int m = 0; m < 4; m++) begin
            fastMode = m[1];
            newLive();
            expCtx = liveCtx;
            irqReq = 1'b1;
            busyCnt = 0;
            do begin
                @(negedge clock);
                busyCnt++;
            end while (irqAck !== 1'b1 && busyCnt < 4);
            chk({irqAck, ctxLoad, inService, ctxOut.pc}, {3'b111, `ICR_VECTOR});
            savedQ.push_back(expCtx);
            newLive();
            // Request held high while in service must stay unanswered
            repeat (4) begin
                @(negedge clock);
                chk(irqAck, 1'b0);
            end
            irqReq = 1'b0;
            opcode = 12'h00c;
            opValid = 1'b1;
            @(negedge clock);
            chk({ctxLoad, retBusy, counterLoad}, 3'h0);
            opcode = m[0] ? `ICR_OP_RETIW : `ICR_OP_RETI;
            // A request beside the adjusting return must lose the cycle; the plain return runs with no request
            irqReq = m[0];
            expCnt = (int'(counterIn) + int'(liveCtx.acc)) % 256;
            @(negedge clock);
            opValid = 1'b0;
            irqReq = 1'b0;
            chk({counterLoad, ctxLoad, irqAck}, {m[0], 2'b00});
            if (m[0]) chk(counterOut, expCnt[7:0]);
            busyCnt = 0;
            while (retBusy === 1'b1 && busyCnt < 8) begin
                busyCnt++;
                chk(ctxLoad, 1'b0);
                @(negedge clock);
            end
            chk(36'(busyCnt), m[1] ? 36'h3 : 36'h2);
            chk({ctxLoad, inService, ctxOut}, {2'b10, savedQ.pop_front()});
        end
        results();
    end
endmodule
